// ==== verilog/bjsc_top.sv ====
// branch, jump, skip and compare control behind an axi4-lite slave
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bjsc_defs.svh"
module bjsc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output bjsc_pkg::bjsc_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output bjsc_pkg::bjsc_resp_t rresp,
  output logic rvalid,
  input wire logic rready
);
  import bjsc_pkg::*;

  logic aw_held_reg, w_held_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wbuf_reg;
  logic [3:0] wstb_reg;
  logic [31:0] insn_reg, oper_reg;
  logic [15:0] pc_reg, ptr_reg;
  logic [7:0] status_register_reg;
  bjsc_state_e st_reg;
  logic [2:0] cnt_reg;
  bjsc_res_s res_next, res_reg;
  logic [15:0] stack_reg [0:7];
  logic [2:0] sp_reg;
  logic last_taken_reg;
  logic [2:0] last_cyc_reg;
  logic aw_take, w_take, ar_take, wr_do, go, commit, rvalid_next;
  bjsc_cmd_e cmd;
  logic [2:0] bidx;
  logic [15:0] arg, seq, brto, skipto;
  logic [7:0] ra, rb, io;
  logic br, sk, cond;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a <= `BJSC_OFF_STAT && a[1:0] == 2'h0;
  endfunction

  function automatic logic [15:0] sext7(input logic [15:0] v);
    return {{9{v[6]}}, v[6:0]};
  endfunction

  function automatic logic [15:0] sext12(input logic [15:0] v);
    return {{4{v[11]}}, v[11:0]};
  endfunction

  function automatic logic [7:0] cmp_flags(input logic [7:0] sr, input logic [7:0] a,
                                           input logic [7:0] b, input logic wc);
    logic [7:0] r;
    logic [7:0] f;
    r = a - b - {7'h00, wc & sr[`BJSC_SR_C]};
    f = sr;
    f[`BJSC_SR_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    f[`BJSC_SR_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    f[`BJSC_SR_N] = r[7];
    f[`BJSC_SR_S] = r[7] ^ f[`BJSC_SR_V];
    f[`BJSC_SR_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    f[`BJSC_SR_Z] = (r == 8'h00) & (~wc | sr[`BJSC_SR_Z]);
    return f;
  endfunction

  // bus handshake terms
  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  assign ar_take = arvalid & arready;
  assign wr_do = aw_held_reg & w_held_reg & ~bvalid;
  assign go = wr_do && st_reg == st_idle && waddr_reg == `BJSC_OFF_CTRL
              && wstb_reg[0] && wbuf_reg[0];
  assign commit = st_reg == st_run && cnt_reg == 3'h1;
  assign rvalid_next = ar_take | (rvalid & ~rready);

  // write address and data, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wbuf_reg <= `BJSC_RST_WORD;
      wstb_reg <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= awaddr;
      end else if (wr_do) begin
        aw_held_reg <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wbuf_reg <= wdata;
        wstb_reg <= wstrb;
      end else if (wr_do) begin
        w_held_reg <= 1'b0;
      end
      awready <= ~(aw_take | (aw_held_reg & ~wr_do));
      wready <= ~(w_take | (w_held_reg & ~wr_do));
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `BJSC_RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp <= mapped(waddr_reg) ? `BJSC_RESP_OKAY : `BJSC_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      arready <= 1'b0;
      rdata <= `BJSC_RST_WORD;
      rresp <= `BJSC_RESP_OKAY;
    end else begin
      rvalid <= rvalid_next;
      arready <= ~rvalid_next;
      if (ar_take) begin
        rresp <= mapped(araddr) ? `BJSC_RESP_OKAY : `BJSC_RESP_SLVERR;
        case (araddr)
          `BJSC_OFF_CTRL: rdata <= {31'h0, st_reg == st_run};
          `BJSC_OFF_INSN: rdata <= insn_reg;
          `BJSC_OFF_PC: rdata <= {16'h0000, pc_reg};
          `BJSC_OFF_STATUS_REGISTER: rdata <= {24'h000000, status_register_reg};
          `BJSC_OFF_OPER: rdata <= oper_reg;
          `BJSC_OFF_PTR: rdata <= {16'h0000, ptr_reg};
          `BJSC_OFF_STAT: rdata <= {25'h0, sp_reg, last_taken_reg, last_cyc_reg};
          default: rdata <= `BJSC_RST_WORD;
        endcase
      end
    end
  end

  // operand registers, frozen while an instruction runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      insn_reg <= `BJSC_RST_WORD;
      oper_reg <= `BJSC_RST_WORD;
      ptr_reg <= `BJSC_RST_PC;
    end else if (wr_do && st_reg == st_idle) begin
      if (waddr_reg == `BJSC_OFF_INSN) begin
        insn_reg <= merge(insn_reg, wbuf_reg, wstb_reg);
      end
      if (waddr_reg == `BJSC_OFF_OPER) begin
        oper_reg <= merge(oper_reg, wbuf_reg, wstb_reg);
      end
      if (waddr_reg == `BJSC_OFF_PTR) begin
        ptr_reg <= 16'(merge({16'h0000, ptr_reg}, wbuf_reg, wstb_reg));
      end
    end
  end

  // decode and next program counter
  always_comb begin
    cmd = bjsc_cmd_e'(insn_reg[5:0]);
    bidx = insn_reg[8:6];
    arg = insn_reg[31:16];
    ra = oper_reg[7:0];
    rb = oper_reg[15:8];
    io = oper_reg[23:16];
    seq = pc_reg + 16'h0001;
    brto = pc_reg + sext7(arg) + 16'h0001;
    skipto = pc_reg + (insn_reg[`BJSC_INSN_LONG] ? 16'h0003 : 16'h0002);
    br = 1'b0;
    sk = 1'b0;
    cond = 1'b0;
    res_next = '{pc: seq, ret: seq, status_register: status_register_reg, cyc: `BJSC_CYC_ONE,
                 taken: 1'b0, push: 1'b0, pop: 1'b0};
    case (cmd)
      c_relative_jump: begin
        res_next.pc = pc_reg + sext12(arg) + 16'h0001;
        res_next.cyc = `BJSC_CYC_TWO;
      end
      c_indirect_jump: begin
        res_next.pc = ptr_reg;
        res_next.cyc = `BJSC_CYC_TWO;
      end
      c_absolute_jump: begin
        res_next.pc = arg;
        res_next.cyc = `BJSC_CYC_THREE;
      end
      c_relative_subroutine_invoke: begin
        res_next.pc = pc_reg + sext12(arg) + 16'h0001;
        res_next.cyc = `BJSC_CYC_THREE;
        res_next.push = 1'b1;
      end
      c_indirect_subroutine_invoke: begin
        res_next.pc = ptr_reg;
        res_next.cyc = `BJSC_CYC_THREE;
        res_next.push = 1'b1;
      end
      c_absolute_subroutine_invoke: begin
        res_next.pc = arg;
        res_next.ret = pc_reg + 16'h0002;
        res_next.cyc = `BJSC_CYC_FOUR;
        res_next.push = 1'b1;
      end
      c_subroutine_exit: begin
        res_next.pc = stack_reg[sp_reg - 3'h1];
        res_next.cyc = `BJSC_CYC_FOUR;
        res_next.pop = 1'b1;
      end
      c_interrupt_handler_exit: begin
        res_next.pc = stack_reg[sp_reg - 3'h1];
        res_next.cyc = `BJSC_CYC_FOUR;
        res_next.pop = 1'b1;
        res_next.status_register[`BJSC_SR_I] = 1'b1;
      end
      c_compare_and_skip_on_match: begin
        sk = 1'b1;
        cond = ra == rb;
      end
      c_compare_registers: res_next.status_register = cmp_flags(status_register_reg, ra, rb, 1'b0);
      c_compare_registers_with_borrow: res_next.status_register = cmp_flags(status_register_reg, ra, rb, 1'b1);
      c_compare_with_constant: res_next.status_register = cmp_flags(status_register_reg, ra, arg[7:0], 1'b0);
      c_skip_on_reg_bit_zero: begin
        sk = 1'b1;
        cond = ~ra[bidx];
      end
      c_skip_on_reg_bit_one: begin
        sk = 1'b1;
        cond = ra[bidx];
      end
      c_skip_on_io_bit_zero: begin
        sk = 1'b1;
        cond = ~io[bidx];
      end
      c_skip_on_io_bit_one: begin
        sk = 1'b1;
        cond = io[bidx];
      end
      default: begin
        br = 1'b1;
        case (cmd)
          c_branch_on_status_bit_one: cond = status_register_reg[bidx];
          c_branch_on_status_bit_zero: cond = ~status_register_reg[bidx];
          c_branch_on_equal: cond = status_register_reg[`BJSC_SR_Z];
          c_branch_on_not_equal: cond = ~status_register_reg[`BJSC_SR_Z];
          c_branch_on_carry_one: cond = status_register_reg[`BJSC_SR_C];
          c_branch_on_carry_zero: cond = ~status_register_reg[`BJSC_SR_C];
          c_branch_unsigned_not_below: cond = ~status_register_reg[`BJSC_SR_C];
          c_branch_unsigned_below: cond = status_register_reg[`BJSC_SR_C];
          c_branch_on_negative: cond = status_register_reg[`BJSC_SR_N];
          c_branch_on_positive: cond = ~status_register_reg[`BJSC_SR_N];
          c_branch_signed_not_less: cond = ~(status_register_reg[`BJSC_SR_N] ^ status_register_reg[`BJSC_SR_V]);
          c_branch_signed_less: cond = status_register_reg[`BJSC_SR_N] ^ status_register_reg[`BJSC_SR_V];
          c_branch_on_half_carry_one: cond = status_register_reg[`BJSC_SR_H];
          c_branch_on_half_carry_zero: cond = ~status_register_reg[`BJSC_SR_H];
          c_branch_on_transfer_bit_one: cond = status_register_reg[`BJSC_SR_T];
          c_branch_on_transfer_bit_zero: cond = ~status_register_reg[`BJSC_SR_T];
          c_branch_on_overflow_one: cond = status_register_reg[`BJSC_SR_V];
          c_branch_on_overflow_zero: cond = ~status_register_reg[`BJSC_SR_V];
          default: br = 1'b0;
        endcase
      end
    endcase
    if (br && cond) begin
      res_next.pc = brto;
      res_next.cyc = `BJSC_CYC_TWO;
      res_next.taken = 1'b1;
    end
    if (sk && cond) begin
      res_next.pc = skipto;
      res_next.cyc = insn_reg[`BJSC_INSN_LONG] ? `BJSC_CYC_THREE : `BJSC_CYC_TWO;
      res_next.taken = 1'b1;
    end
  end

  // sequencer: stays busy for the instruction's cycle count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= st_idle;
      cnt_reg <= 3'h0;
      res_reg <= '0;
      last_taken_reg <= 1'b0;
      last_cyc_reg <= 3'h0;
    end else begin
      case (st_reg)
        st_idle: begin
          if (go) begin
            st_reg <= st_run;
            cnt_reg <= res_next.cyc;
            res_reg <= res_next;
          end
        end
        st_run: begin
          cnt_reg <= cnt_reg - 3'h1;
          if (commit) begin
            st_reg <= st_idle;
            last_taken_reg <= res_reg.taken;
            last_cyc_reg <= res_reg.cyc;
          end
        end
        default: st_reg <= st_idle;
      endcase
    end
  end

  // program counter and status register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_reg <= `BJSC_RST_PC;
      status_register_reg <= `BJSC_RST_STATUS_REGISTER;
    end else if (commit) begin
      pc_reg <= res_reg.pc;
      status_register_reg <= res_reg.status_register;
    end else if (wr_do && st_reg == st_idle) begin
      if (waddr_reg == `BJSC_OFF_PC) begin
        pc_reg <= 16'(merge({16'h0000, pc_reg}, wbuf_reg, wstb_reg));
      end
      if (waddr_reg == `BJSC_OFF_STATUS_REGISTER) begin
        status_register_reg <= 8'(merge({24'h000000, status_register_reg}, wbuf_reg, wstb_reg));
      end
    end
  end

  // return address stack, circular
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_reg <= 3'h0;
    end else if (commit && res_reg.push) begin
      stack_reg[sp_reg] <= res_reg.ret;
      sp_reg <= sp_reg + 3'h1;
    end else if (commit && res_reg.pop) begin
      sp_reg <= sp_reg - 3'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_bit_one_branch: assert property (
    go && cmd == c_branch_on_status_bit_one && status_register_reg[bidx] |=>
    cnt_reg == 3'h2 && res_reg.pc == $past(pc_reg) + sext7($past(arg)) + 16'h0001)
    else $error("status bit one branch wrong");
  chk_bit_zero_skip: assert property (
    go && cmd == c_branch_on_status_bit_zero && status_register_reg[bidx] |=>
    cnt_reg == 3'h1 && res_reg.pc == $past(pc_reg) + 16'h0001)
    else $error("status bit zero branch taken wrongly");
  chk_equal_branch: assert property (
    go && cmd == c_branch_on_equal |=> res_reg.taken == $past(status_register_reg[`BJSC_SR_Z]))
    else $error("equal branch ignores zero flag");
  chk_below_alias: assert property (
    go && cmd == c_branch_unsigned_below |=> res_reg.taken == $past(status_register_reg[`BJSC_SR_C]))
    else $error("unsigned below branch wrong");
  chk_signed_less: assert property (
    go && cmd == c_branch_signed_less |=>
    res_reg.taken == ($past(status_register_reg[`BJSC_SR_N]) ^ $past(status_register_reg[`BJSC_SR_V])))
    else $error("signed less branch wrong");
  chk_skip_long: assert property (
    go && cmd == c_skip_on_reg_bit_one && ra[bidx] && insn_reg[`BJSC_INSN_LONG] |=>
    st_reg == st_run [*3] ##1 st_reg == st_idle && pc_reg == $past(pc_reg, 4) + 16'h0003)
    else $error("long skip wrong");
  chk_cmp_keeps_flags: assert property (
    go && cmd == c_compare_and_skip_on_match |=> ##1 status_register_reg == $past(status_register_reg, 2))
    else $error("compare and skip changed flags");
  chk_compare_one: assert property (
    go && cmd == c_compare_registers && ra == rb |=>
    ##1 st_reg == st_idle && status_register_reg[`BJSC_SR_Z] && !status_register_reg[`BJSC_SR_C])
    else $error("compare flags wrong");
  chk_indirect_jump: assert property (
    go && cmd == c_indirect_jump |=> st_reg == st_run [*2] ##1 pc_reg == $past(ptr_reg, 3))
    else $error("indirect jump wrong");
  chk_exit_sets_i: assert property (
    go && cmd == c_interrupt_handler_exit |=> ##4 status_register_reg[`BJSC_SR_I] && st_reg == st_idle)
    else $error("interrupt exit did not set i");
endmodule
`default_nettype wire

// ==== verilog/bjsc_defs.svh ====
// register map, field positions, reset values and cycle counts
`ifndef BJSC_DEFS_SVH
`define BJSC_DEFS_SVH
// What this block does
// - status bit one: branch to pc+offset+1
// - status bit zero: branch to pc+offset+1
// - equal/not-equal branches test zero flag
// - carry one/zero branches test carry flag
// - unsigned branches alias carry zero/one
// - negative/positive branches test negative flag
// - signed not-less taken when n xor v zero
// - signed less taken when n xor v one
// - half-carry branches test half-carry flag
// - transfer-bit branches test t flag
// - overflow branches test overflow flag
// - register bit zero skips next instruction
// - register bit one skips next instruction
// - io bit zero skips next instruction
// - io bit one skips next instruction
// - equal operands skip, flags kept
// - compares set z n v c h, one cycle
// - indirect jump loads pointer, two cycles
// - indirect invoke pushes, loads pointer, three cycles
`define BJSC_OFF_CTRL 8'h00
`define BJSC_OFF_INSN 8'h04
`define BJSC_OFF_PC 8'h08
`define BJSC_OFF_STATUS_REGISTER 8'h0c
`define BJSC_OFF_OPER 8'h10
`define BJSC_OFF_PTR 8'h14
`define BJSC_OFF_STAT 8'h18
`define BJSC_RST_PC 16'h0000
`define BJSC_RST_STATUS_REGISTER 8'h00
`define BJSC_RST_WORD 32'h0000_0000
`define BJSC_SR_C 0
`define BJSC_SR_Z 1
`define BJSC_SR_N 2
`define BJSC_SR_V 3
`define BJSC_SR_S 4
`define BJSC_SR_H 5
`define BJSC_SR_T 6
`define BJSC_SR_I 7
`define BJSC_INSN_LONG 9
`define BJSC_CYC_ONE 3'h1
`define BJSC_CYC_TWO 3'h2
`define BJSC_CYC_THREE 3'h3
`define BJSC_CYC_FOUR 3'h4
`define BJSC_RESP_OKAY 2'h0
`define BJSC_RESP_SLVERR 2'h2
`endif

// ==== verilog/bjsc_pkg.sv ====
// types for the branch, jump and skip control block
`default_nettype none
package bjsc_pkg;
  typedef enum logic [5:0] {
    c_relative_jump = 6'h00, c_indirect_jump = 6'h01, c_absolute_jump = 6'h02,
    c_relative_subroutine_invoke = 6'h03, c_indirect_subroutine_invoke = 6'h04,
    c_absolute_subroutine_invoke = 6'h05, c_subroutine_exit = 6'h06,
    c_interrupt_handler_exit = 6'h07, c_compare_and_skip_on_match = 6'h08,
    c_compare_registers = 6'h09, c_compare_registers_with_borrow = 6'h0a,
    c_compare_with_constant = 6'h0b, c_skip_on_reg_bit_zero = 6'h0c,
    c_skip_on_reg_bit_one = 6'h0d, c_skip_on_io_bit_zero = 6'h0e,
    c_skip_on_io_bit_one = 6'h0f, c_branch_on_status_bit_one = 6'h10,
    c_branch_on_status_bit_zero = 6'h11, c_branch_on_equal = 6'h12,
    c_branch_on_not_equal = 6'h13, c_branch_on_carry_one = 6'h14,
    c_branch_on_carry_zero = 6'h15, c_branch_unsigned_not_below = 6'h16,
    c_branch_unsigned_below = 6'h17, c_branch_on_negative = 6'h18,
    c_branch_on_positive = 6'h19, c_branch_signed_not_less = 6'h1a,
    c_branch_signed_less = 6'h1b, c_branch_on_half_carry_one = 6'h1c,
    c_branch_on_half_carry_zero = 6'h1d, c_branch_on_transfer_bit_one = 6'h1e,
    c_branch_on_transfer_bit_zero = 6'h1f, c_branch_on_overflow_one = 6'h20,
    c_branch_on_overflow_zero = 6'h21
  } bjsc_cmd_e;
  typedef enum logic [0:0] {st_idle = 1'b0, st_run = 1'b1} bjsc_state_e;
  typedef logic [1:0] bjsc_resp_t;
  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] ret;
    logic [7:0] status_register;
    logic [2:0] cyc;
    logic taken;
    logic push;
    logic pop;
  } bjsc_res_s;
endpackage
`default_nettype wire

// ==== testbench/bjsc_host_model.sv ====
// register bus master standing in for software
`timescale 1ns/1ps
`default_nettype none
module bjsc_host_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire bjsc_pkg::bjsc_resp_t bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire bjsc_pkg::bjsc_resp_t rresp,
  input wire logic rvalid,
  output logic rready,
  output logic hung
);
  import bjsc_pkg::*;
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, hung} = '0;

  // one write, address and data offered together
  task automatic write_word(input logic [7:0] a, input logic [31:0] d, output bjsc_resp_t r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 64) hung <= 1'b1;
  endtask

  // one read, data taken at the edge that shows rvalid
  task automatic read_word(input logic [7:0] a, output logic [31:0] d, output bjsc_resp_t r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 64) hung <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== testbench/bjsc_top_tb.sv ====
// self-checking bench for the branch, jump, skip and compare control
`timescale 1ns/1ps
`default_nettype none
`include "bjsc_defs.svh"
module bjsc_top_tb;
  import bjsc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, word;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, hung;
  bjsc_resp_t bresp, rresp, resp;
  int fail_count = 0;
  int check_count = 0;

  always #25 aclk = ~aclk;

  bjsc_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  bjsc_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .hung(hung));

  task automatic stop_test;
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // a bus wait that ran out ends the run
  always @(posedge aclk) begin
    if (hung) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // load operands, start, poll busy
  task automatic execute(input logic [31:0] insn, input logic [15:0] pc, input logic [7:0] sr,
                         input logic [23:0] oper, input logic [15:0] ptr);
    int n;
    host.write_word(`BJSC_OFF_PC, {16'h0000, pc}, resp);
    host.write_word(`BJSC_OFF_STATUS_REGISTER, {24'h000000, sr}, resp);
    host.write_word(`BJSC_OFF_OPER, {8'h00, oper}, resp);
    host.write_word(`BJSC_OFF_PTR, {16'h0000, ptr}, resp);
    host.write_word(`BJSC_OFF_INSN, insn, resp);
    host.write_word(`BJSC_OFF_CTRL, 32'h00000001, resp);
    for (n = 0; n < 20; n++) begin
      host.read_word(`BJSC_OFF_CTRL, word, resp);
      if (word[0] === 1'b0) break;
    end
    if (n == 20) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic expect_result(input logic [15:0] pc, input logic [7:0] sr, input logic [7:0] srm,
                               input logic [3:0] st, input logic [3:0] stm);
    host.read_word(`BJSC_OFF_PC, word, resp);
    check(word, {16'h0000, pc});
    host.read_word(`BJSC_OFF_STATUS_REGISTER, word, resp);
    check(word & {24'h000000, srm}, {24'h000000, sr & srm});
    host.read_word(`BJSC_OFF_STAT, word, resp);
    check(word & {28'h0000000, stm}, {28'h0000000, st & stm});
  endtask

  task automatic test_reset;
    host.read_word(`BJSC_OFF_PC, word, resp);
    check(word, 32'h00000000);
    host.read_word(`BJSC_OFF_STATUS_REGISTER, word, resp);
    check(word, 32'h00000000);
    host.read_word(8'h1c, word, resp);
    check({30'h0, resp}, 32'h00000002);
    host.write_word(8'h1c, 32'hffffffff, resp);
    check({30'h0, resp}, 32'h00000002);
  endtask

  // every branch code against four flag patterns, offset minus two
  task automatic test_branches;
    logic [7:0] flags [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
    logic [5:0] c;
    logic f;
    logic t;
    for (int i = 16; i <= 33; i++) begin
      for (int j = 0; j < 4; j++) begin
        c = i[5:0];
        case (c)
          6'h12, 6'h13: f = flags[j][1];
          6'h14, 6'h15, 6'h16, 6'h17: f = flags[j][0];
          6'h18, 6'h19: f = flags[j][2];
          6'h1a, 6'h1b: f = ~(flags[j][2] ^ flags[j][3]);
          6'h1c, 6'h1d: f = flags[j][5];
          6'h1e, 6'h1f: f = flags[j][6];
          default: f = flags[j][3];
        endcase
        t = (c == 6'h16 || c == 6'h17) ? (f == c[0]) : (f != c[0]);
        execute({16'h007e, 7'h00, 3'h3, c}, 16'h0100, flags[j], 24'h000000, 16'h0000);
        expect_result(t ? 16'h00ff : 16'h0101, flags[j], 8'hff,
                      {t, t ? 3'h2 : 3'h1},
                      4'hf);
      end
    end
  endtask

  // bit index two, short and long skipped word
  task automatic test_skips;
    logic [23:0] ops [2] = '{24'h5a5a5a, 24'ha53ca5};
    logic [5:0] cmds [5] = '{6'h08, 6'h0c, 6'h0d, 6'h0e, 6'h0f};
    logic s;
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 2; j++) begin
        for (int l = 0; l < 2; l++) begin
          case (cmds[i])
            6'h08: s = ops[j][7:0] == ops[j][15:8];
            6'h0c: s = !ops[j][2];
            6'h0d: s = ops[j][2];
            6'h0e: s = !ops[j][18];
            default: s = ops[j][18];
          endcase
          execute({22'h000000, l[0], 3'h2, cmds[i]}, 16'h0200, 8'h3f, ops[j], 16'h0000);
          expect_result(s ? (l ? 16'h0203 : 16'h0202) : 16'h0201, 8'h3f, 8'hff,
                        {s, s ? (l ? 3'h3 : 3'h2) : 3'h1}, 4'hf);
        end
      end
    end
  endtask

  function automatic logic [7:0] cmp_flags(input logic [5:0] c, input logic [7:0] d,
                                           input logic [7:0] k, input logic [7:0] s);
    logic [7:0] r;
    logic [7:0] f;
    r = d - k - ((c == 6'h0a) ? {7'h00, s[0]} : 8'h00);
    f = s;
    f[0] = (!d[7] & k[7]) | (k[7] & r[7]) | (r[7] & !d[7]);
    f[1] = (r == 8'h00) & ((c == 6'h0a) ? s[1] : 1'b1);
    f[2] = r[7];
    f[3] = (d[7] & !k[7] & !r[7]) | (!d[7] & k[7] & r[7]);
    f[5] = (!d[3] & k[3]) | (k[3] & r[3]) | (r[3] & !d[3]);
    return f;
  endfunction

  task automatic test_compares;
    logic [5:0] c [6] = '{6'h09, 6'h09, 6'h0a, 6'h0a, 6'h0b, 6'h09};
    logic [7:0] d [6] = '{8'h10, 8'h80, 8'h05, 8'h05, 8'h42, 8'h33};
    logic [7:0] k [6] = '{8'h20, 8'h01, 8'h04, 8'h04, 8'h42, 8'h33};
    logic [7:0] s [6] = '{8'h00, 8'h00, 8'h01, 8'h03, 8'hc0, 8'h01};
    for (int i = 0; i < 6; i++) begin
      execute({8'h00, k[i], 10'h000, c[i]}, 16'h0300, s[i], {8'h00, k[i], d[i]}, 16'h0000);
      expect_result(16'h0301, cmp_flags(c[i], d[i], k[i], s[i]), 8'hef, 4'h1, 4'h7);
    end
  endtask

  task automatic flow_step(input logic [5:0] c, input logic [15:0] arg, input logic [15:0] pc,
                           input logic [15:0] ptr, input logic [15:0] npc, input logic [2:0] cyc,
                           input logic [7:0] sr);
    execute({arg, 10'h000, c}, pc, 8'h5a, 24'h000000, ptr);
    expect_result(npc, sr, 8'hff, {1'b0, cyc}, 4'h7);
  endtask

  // jumps, then three nested invokes unwound in reverse
  task automatic test_flow;
    flow_step(6'h00, 16'h0ffd, 16'h0200, 16'h0000, 16'h01fe, 3'h2, 8'h5a);
    flow_step(6'h02, 16'h1234, 16'h0200, 16'h0000, 16'h1234, 3'h3, 8'h5a);
    flow_step(6'h01, 16'h0000, 16'h0200, 16'hbeef, 16'hbeef, 3'h2, 8'h5a);
    flow_step(6'h03, 16'h0010, 16'h0300, 16'h0000, 16'h0311, 3'h3, 8'h5a);
    flow_step(6'h04, 16'h0000, 16'h0400, 16'h0abc, 16'h0abc, 3'h3, 8'h5a);
    flow_step(6'h05, 16'h2222, 16'h0500, 16'h0000, 16'h2222, 3'h4, 8'h5a);
    flow_step(6'h06, 16'h0000, 16'h2222, 16'h0000, 16'h0502, 3'h4, 8'h5a);
    flow_step(6'h07, 16'h0000, 16'h0600, 16'h0000, 16'h0401, 3'h4, 8'hda);
    flow_step(6'h06, 16'h0000, 16'h0700, 16'h0000, 16'h0301, 3'h4, 8'h5a);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_branches();
    test_skips();
    test_compares();
    test_flow();
    stop_test();
  end
endmodule
`default_nettype wire
